// ===== dv/sac_analog_model.sv
// Behavioural analog core and RC oscillator on the far side of the control block
`timescale 1ns/10ps
`default_nettype none
module sac_analog_model
	import sac_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             enable_i,
	input  wire logic             ref_ext_i,
	input  wire logic [RES_W-1:0] trial_i,
	input  wire logic [RES_W-1:0] vin_int_i,
	input  wire logic [RES_W-1:0] vin_ext_i,
	output logic                  comp_o,
	output logic                  rc_clk_o
);
	logic toggle;

	// The RC oscillator runs free at seven system clock periods, its rising edges landing on clock rising edges
	initial begin
		rc_clk_o = 1'b0;
		forever #17.5 rc_clk_o = ~rc_clk_o;
	end

	// A powered-down comparator holds nothing useful: it flips every clock
	always @(posedge clk_i) begin
		toggle <= (toggle === 1'b1) ? 1'b0 : 1'b1;
	end

	// The reference choice decides which scaled input the trial code is weighed against
	always_comb begin
		if (enable_i !== 1'b1)
			comp_o = toggle;
		else
			comp_o = ((ref_ext_i ? vin_ext_i : vin_int_i) >= trial_i);
	end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
	$display("BAD %s exp=%h got=%h", nm, ex, got); end end
module testbench;
	import sac_pkg::*;
	logic              clk_i, rstn_i, psel, penable, pwrite, trigger, sleep, rc_clk, comp;
	logic [APB_AW-1:0] paddr;
	logic [APB_DW-1:0] pwdata, prdata_o, r;
	logic              pready_o, pslverr_o, e, core_en, ref_ext, sh, tmr_rst, wake_o, done_flag_o;
	logic [RES_W-1:0]  trial, vin_int, vin_ext;
	int                err_total, n_compared, cyc;

	sac_ctrl u_sac_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .trigger_i(trigger), .sleep_i(sleep),
		.rc_clk_i(rc_clk), .comp_i(comp), .core_enable_o(core_en), .ref_external_o(ref_ext),
		.sample_hold_o(sh), .trial_code_o(trial), .timer_reset_o(tmr_rst), .wake_o(wake_o),
		.done_flag_o(done_flag_o));
	sac_analog_model u_sac_analog_model (.clk_i(clk_i), .enable_i(core_en), .ref_ext_i(ref_ext),
		.trial_i(trial), .vin_int_i(vin_int), .vin_ext_i(vin_ext), .comp_o(comp),
		.rc_clk_o(rc_clk));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the answer
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
		// One more edge so outputs launched by the write have settled for the caller
		@(posedge clk_i);
	endtask

	task automatic rdchk(input string nm, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] ex);
		apb(1'b0, a, 32'h0);
		`CHK(nm, ex, r)
	endtask

	task automatic wait_flag(input int n);
		int i;
		i = 0;
		while (done_flag_o !== 1'b1 && i < n) begin
			@(posedge clk_i);
			i++;
		end
		`CHK("done flag", 1'b1, done_flag_o)
	endtask

	function automatic logic [31:0] hi_w(input logic [9:0] v, input logic f);
		return f ? {30'h0, v[9:8]} : {24'h0, v[9:2]};
	endfunction
	function automatic logic [31:0] lo_w(input logic [9:0] v, input logic f);
		return f ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00};
	endfunction

	task automatic t_regs();
		rdchk("ctrl", OFS_CTRL, 32'h0);
		rdchk("status", OFS_STATUS, 32'h0);
		rdchk("res hi", OFS_RES_HI, 32'h0);
		rdchk("res lo", OFS_RES_LO, 32'h0);
		rdchk("unmapped", 8'h10, 32'h0);
		`CHK("slverr", 1'b1, e)
		apb(1'b1, OFS_RES_HI, 32'hA5);
		rdchk("res hi rw", OFS_RES_HI, 32'hA5);
		apb(1'b1, OFS_CTRL, 32'h2);
		repeat (12) @(posedge clk_i);
		rdchk("go while off", OFS_STATUS, 32'h0);
		`CHK("core off", 1'b0, core_en)
		$display("test regs done");
	endtask

	task automatic t_conv(input logic f, input logic x, input logic [9:0] vi, input logic [9:0] ve);
		logic [31:0] c;
		c = {26'h0, f, x, 2'b01};
		vin_int = vi;
		vin_ext = ve;
		apb(1'b1, OFS_CTRL, c);
		`CHK("core on", 1'b1, core_en)
		`CHK("ref sel", x, ref_ext)
		`CHK("tracking", 1'b1, sh)
		apb(1'b1, OFS_CTRL, c | 32'h2);
		@(posedge clk_i);
		`CHK("hold", 1'b0, sh)
		wait_flag(200);
		rdchk("go cleared", OFS_CTRL, c);
		rdchk("hi", OFS_RES_HI, hi_w(x ? ve : vi, f));
		rdchk("lo", OFS_RES_LO, lo_w(x ? ve : vi, f));
		repeat (30) @(posedge clk_i);
		`CHK("flag sticky", 1'b1, done_flag_o)
		apb(1'b1, OFS_STATUS, 32'h1);
		`CHK("flag cleared", 1'b0, done_flag_o)
		$display("test conversion done");
	endtask

	task automatic t_abort();
		logic [9:0] m, x, got;
		logic       ok;
		vin_int = 10'h2CE;
		apb(1'b1, OFS_CTRL, 32'h3);
		// Lands the abort after five resolved bits
		repeat (38) @(posedge clk_i);
		apb(1'b1, OFS_CTRL, 32'h1);
		wait_flag(100);
		apb(1'b0, OFS_RES_HI, 32'h0);
		got[9:2] = r[7:0];
		apb(1'b0, OFS_RES_LO, 32'h0);
		got[1:0] = r[7:6];
		ok = 1'b0;
		for (int k = 1; k < 10; k++) begin
			m = 10'h3FF << (10 - k);
			x = (vin_int & m) | (vin_int[10-k] ? ~m : 10'h000);
			if (x === got)
				ok = 1'b1;
		end
		`CHK("partial result", 1'b1, ok)
		apb(1'b1, OFS_STATUS, 32'h1);
		$display("test abort done");
	endtask

	task automatic t_trigger();
		vin_int = 10'h155;
		@(posedge clk_i);
		trigger <= 1'b1;
		@(posedge clk_i);
		trigger <= 1'b0;
		#1;
		`CHK("timer reset", 1'b1, tmr_rst)
		wait_flag(200);
		rdchk("trig hi", OFS_RES_HI, hi_w(vin_int, 1'b0));
		apb(1'b1, OFS_STATUS, 32'h1);
		$display("test trigger done");
	endtask

	task automatic t_sleep_sys();
		apb(1'b1, OFS_CTRL, 32'h3);
		repeat (20) @(posedge clk_i);
		sleep <= 1'b1;
		repeat (6) @(posedge clk_i);
		`CHK("core halted", 1'b0, core_en)
		rdchk("halted", OFS_STATUS, 32'h4);
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK("on kept", 1'b1, r[0])
		sleep <= 1'b0;
		repeat (4) @(posedge clk_i);
		$display("test sleep abort done");
	endtask

	task automatic t_sleep_rc(input logic ie);
		logic [31:0] c;
		c = {26'h0, ie, 5'h11};
		vin_int = 10'h0B3;
		apb(1'b1, OFS_CTRL, c);
		apb(1'b1, OFS_CTRL, c | 32'h2);
		sleep <= 1'b1;
		wait_flag(600);
		repeat (3) @(posedge clk_i);
		`CHK("wake", ie, wake_o)
		`CHK("core after", ie, core_en)
		rdchk("rc hi", OFS_RES_HI, hi_w(vin_int, 1'b0));
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK("on kept", 1'b1, r[0])
		sleep <= 1'b0;
		repeat (4) @(posedge clk_i);
		`CHK("wake cleared", 1'b0, wake_o)
		apb(1'b1, OFS_STATUS, 32'h1);
		$display("test sleep rc done");
	endtask

	task automatic t_reset_mid();
		apb(1'b1, OFS_CTRL, 32'h3);
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		`CHK("core off", 1'b0, core_en)
		rdchk("ctrl", OFS_CTRL, 32'h0);
		rdchk("status", OFS_STATUS, 32'h0);
		$display("test reset done");
	endtask

	initial begin
		cyc = 0;
		forever begin
			@(posedge clk_i);
			cyc++;
			if (cyc == 20000) begin
				err_total++;
				final_report();
			end
		end
	end

	initial begin
		{rstn_i, psel, penable, pwrite, trigger, sleep} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		vin_int = 10'h000;
		vin_ext = 10'h000;
		err_total = 0;
		n_compared = 0;
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_regs();
		t_conv(1'b0, 1'b0, 10'h2D7, 10'h0F0);
		t_conv(1'b1, 1'b1, 10'h1A4, 10'h36B);
		t_abort();
		t_trigger();
		t_sleep_sys();
		t_sleep_rc(1'b1);
		t_sleep_rc(1'b0);
		t_reset_mid();
		final_report();
	end
endmodule
`default_nettype wire

// ===== src/sac_ctrl.sv
// APB-controlled sequencer for a 10-bit SAR converter
// What this block does
// - Ten-bit successive approximation result in result pair
// - Software picks internal or external reference
// - Converter enabled only while converter_on is one
// - Writing go one starts a conversion
// - Completion clears go, sets flag, stores result
// - Clearing go aborts, partial result with filled bits
// - Reset restores registers, converter off, conversion ends
// - Sleep running only on RC clock, extra delay
// - Completion in sleep with interrupt enabled wakes
// - Completion in sleep, interrupt off, converter off
// - Sleep on other clock aborts, turns off
// - Capture trigger sets go and clears timer
// - Left format: result bits 9..2 in high
// - Left format: bits 1..0 top of low
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module sac_ctrl
	import sac_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic [APB_AW-1:0] paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [APB_DW-1:0] pwdata_i,
	output logic      [APB_DW-1:0] prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              trigger_i,
	input  wire logic              sleep_i,
	input  wire logic              rc_clk_i,
	input  wire logic              comp_i,
	output logic                   core_enable_o,
	output logic                   ref_external_o,
	output logic                   sample_hold_o,
	output logic      [RES_W-1:0]  trial_code_o,
	output logic                   timer_reset_o,
	output logic                   wake_o,
	output logic                   done_flag_o
);
	typedef struct packed {
		sac_state_e        state;
		logic              on;
		logic              go;
		logic              refx;
		logic              fmt;
		logic              rcsel;
		logic              ie;
		logic              flag;
		logic              halted;
		logic              wake;
		logic              discard;
		logic              rc_prev;
		logic [3:0]        cnt;
		logic [BYTE_W-1:0] res_hi;
		logic [BYTE_W-1:0] res_lo;
		logic [APB_DW-1:0] prdata;
		logic              pready;
		logic              pslverr;
		logic              timer_reset;
		logic              core_en;
		logic              sh;
		logic [RES_W-1:0]  trial;
	} sac_ctrl_s;

	sac_ctrl_s         r;
	sac_ctrl_s         next_r;
	sac_sar_if         sar_if ();
	logic [1:0]        sync_q;
	logic              rc_sync;
	logic              rc_edge;
	logic              wr;
	logic              rd_phase;
	logic              mapped;
	logic [APB_DW-1:0] rd_data;
	logic              sw_go_set;
	logic              sw_go_clr;
	logic              can_start;
	logic              sleep_kill;
	logic              store;
	logic [BYTE_W-1:0] new_hi;
	logic [BYTE_W-1:0] new_lo;

	// Comparator and RC oscillator come from the analog side
	sac_sync #(
		.W (2)
	) u_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.d_i    ({rc_clk_i, comp_i}),
		.q_o    (sync_q)
	);

	sac_sar u_sar (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.sar    (sar_if.sar)
	);

	assign rc_sync   = sync_q[1];
	assign rc_edge   = rc_sync && !r.rc_prev;
	assign sar_if.comp = sync_q[0];

	// One wait state: pready rises in the second access cycle
	assign wr       = psel_i && penable_i && r.pready && pwrite_i;
	assign rd_phase = psel_i && penable_i && !r.pready;
	assign mapped   = (paddr_i == OFS_CTRL) || (paddr_i == OFS_STATUS) ||
		(paddr_i == OFS_RES_HI) || (paddr_i == OFS_RES_LO);

	always_comb begin
		rd_data = '0;
		unique case (paddr_i)
			OFS_CTRL: begin
				rd_data[CTRL_ON]    = r.on;
				rd_data[CTRL_GO]    = r.go;
				rd_data[CTRL_REFX]  = r.refx;
				rd_data[CTRL_FMT]   = r.fmt;
				rd_data[CTRL_RCSEL] = r.rcsel;
				rd_data[CTRL_IE]    = r.ie;
			end
			OFS_STATUS: begin
				rd_data[STAT_DONE] = r.flag;
				rd_data[STAT_BUSY] = (r.state != SAC_IDLE);
				rd_data[STAT_HALT] = r.halted;
				rd_data[STAT_WAKE] = r.wake;
			end
			OFS_RES_HI: rd_data[BYTE_W-1:0] = r.res_hi;
			OFS_RES_LO: rd_data[BYTE_W-1:0] = r.res_lo;
			default: rd_data = '0;
		endcase
	end

	// Result layout is chosen when the result lands, not when it is read
	always_comb begin
		if (!r.fmt) begin
			new_hi = sar_if.result[RES_W-1:2];
			new_lo = {sar_if.result[1:0], 6'h00};
		end else begin
			new_hi = {6'h00, sar_if.result[RES_W-1:BYTE_W]};
			new_lo = sar_if.result[BYTE_W-1:0];
		end
	end

	assign sw_go_set  = wr && (paddr_i == OFS_CTRL) && pwdata_i[CTRL_GO];
	assign sw_go_clr  = wr && (paddr_i == OFS_CTRL) && !pwdata_i[CTRL_GO];
	// Go is honoured only once the converter is already on
	assign can_start  = r.on && !r.halted;
	assign sleep_kill = sleep_i && !r.rcsel && r.on;
	assign store      = sar_if.done && !r.discard;

	always_comb begin
		next_r = r;
		next_r.timer_reset = 1'b0;
		next_r.pready = rd_phase;
		next_r.rc_prev = rc_sync;
		sar_if.start = 1'b0;
		sar_if.abort = 1'b0;
		sar_if.tick = 1'b0;
		if (rd_phase) begin
			next_r.prdata = rd_data;
			next_r.pslverr = !mapped;
		end

		if (wr) begin
			unique case (paddr_i)
				OFS_CTRL: begin
					next_r.on    = pwdata_i[CTRL_ON];
					next_r.refx  = pwdata_i[CTRL_REFX];
					next_r.fmt   = pwdata_i[CTRL_FMT];
					next_r.rcsel = pwdata_i[CTRL_RCSEL];
					next_r.ie    = pwdata_i[CTRL_IE];
					if (sw_go_set && can_start) begin
						next_r.go = 1'b1;
					end else if (sw_go_clr) begin
						next_r.go = 1'b0;
					end
				end
				OFS_STATUS: begin
					if (pwdata_i[STAT_DONE]) begin
						next_r.flag = 1'b0;
					end
				end
				OFS_RES_HI: next_r.res_hi = pwdata_i[BYTE_W-1:0];
				OFS_RES_LO: next_r.res_lo = pwdata_i[BYTE_W-1:0];
				default: next_r.flag = r.flag;
			endcase
		end

		if (trigger_i) begin
			next_r.timer_reset = 1'b1;
			if (can_start && r.state == SAC_IDLE) begin
				next_r.go = 1'b1;
			end
		end

		unique case (r.state)
			SAC_IDLE: begin
				next_r.cnt = CNT_RESET;
				if (r.go && can_start && !sleep_kill) begin
					if (r.rcsel) begin
						next_r.state = SAC_DELAY;
					end else begin
						next_r.state = SAC_CONV;
						sar_if.start = 1'b1;
					end
				end else if (r.go) begin
					next_r.go = 1'b0;
				end
			end
			SAC_DELAY: begin
				// The extra instruction lets the sleep command execute first
				if (!r.go || !r.on || sleep_kill) begin
					next_r.state = SAC_IDLE;
					next_r.go = 1'b0;
				end else if (r.cnt == 4'(INSTR_CYCLES - 1)) begin
					next_r.cnt = CNT_RESET;
					next_r.state = SAC_CONV;
					sar_if.start = 1'b1;
				end else begin
					next_r.cnt = r.cnt + 4'h1;
				end
			end
			SAC_CONV: begin
				if (sar_if.done) begin
					next_r.state = SAC_IDLE;
					next_r.discard = 1'b0;
					next_r.cnt = CNT_RESET;
				end else if (sar_if.busy) begin
					if (sleep_kill || !r.on) begin
						sar_if.abort = 1'b1;
						next_r.discard = 1'b1;
						next_r.go = 1'b0;
					end else if (!r.go) begin
						sar_if.abort = 1'b1;
					end else if (r.rcsel) begin
						sar_if.tick = rc_edge;
					end else if (r.cnt == 4'(BIT_CYCLES - 1)) begin
						sar_if.tick = 1'b1;
						next_r.cnt = CNT_RESET;
					end else begin
						next_r.cnt = r.cnt + 4'h1;
					end
				end
			end
			default: next_r.state = SAC_IDLE;
		endcase

		// Hardware result wins over a software write in the same cycle
		if (store) begin
			next_r.go = 1'b0;
			next_r.flag = 1'b1;
			next_r.res_hi = new_hi;
			next_r.res_lo = new_lo;
			if (sleep_i && r.rcsel) begin
				if (r.ie) begin
					next_r.wake = 1'b1;
				end else begin
					next_r.halted = 1'b1;
				end
			end
		end

		if (sleep_kill) begin
			next_r.halted = 1'b1;
		end
		if (!sleep_i) begin
			next_r.halted = 1'b0;
			next_r.wake = 1'b0;
		end

		next_r.core_en = next_r.on && !next_r.halted;
		next_r.sh = next_r.core_en && (next_r.state != SAC_CONV);
		next_r.trial = sar_if.trial;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// Everything returns to off, any conversion is dropped
			r <= '0;
			r.state <= SAC_IDLE;
			r.res_hi <= RESULT_RESET;
			r.res_lo <= RESULT_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign prdata_o       = r.prdata;
	assign pready_o       = r.pready;
	assign pslverr_o      = r.pslverr;
	assign core_enable_o  = r.core_en;
	assign ref_external_o = r.refx;
	assign sample_hold_o  = r.sh;
	assign trial_code_o   = r.trial;
	assign timer_reset_o  = r.timer_reset;
	assign wake_o         = r.wake;
	assign done_flag_o    = r.flag;

	logic              flag_clr;
	logic [BYTE_W-1:0] chk_hi;
	logic [1:0]        chk_lo;
	assign flag_clr = wr && (paddr_i == OFS_STATUS) && pwdata_i[STAT_DONE];
	assign chk_hi   = sar_if.result[RES_W-1:2];
	assign chk_lo   = sar_if.result[1:0];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_idle_go;
		r.state == SAC_IDLE && r.go && can_start && !sleep_kill;
	endsequence
	sequence s_done_in_sleep;
		store && sleep_i && r.rcsel;
	endsequence

	a_go_start: assert property (s_idle_go and !r.rcsel |=> r.state == SAC_CONV)
		else $error("system-clock start did not enter conversion");
	a_rc_extra_wait: assert property ($rose(r.state == SAC_CONV) && r.rcsel
		|-> $past(r.state == SAC_DELAY, 1) && $past(r.state == SAC_DELAY, 4))
		else $error("RC start skipped the extra instruction wait");
	a_done_store: assert property (store |=> !r.go && r.flag)
		else $error("completion did not clear go and set flag");
	a_flag_sticky: assert property (r.flag && !flag_clr |=> r.flag)
		else $error("done flag dropped without software clear");
	a_set_beats_clr: assert property (store && flag_clr |=> r.flag)
		else $error("clear beat a same-cycle completion");
	a_left_high: assert property (store && !r.fmt |=> r.res_hi == $past(chk_hi))
		else $error("high byte not result bits 9 to 2");
	a_left_low: assert property (store && !r.fmt
		|=> r.res_lo[7:6] == $past(chk_lo) && r.res_lo[5:0] == 6'h00)
		else $error("low byte layout wrong in left format");
	a_off_gate: assert property ((!r.on || r.halted) |-> !core_enable_o)
		else $error("core enabled while converter_on clear");
	a_sleep_abort: assert property (sleep_kill && r.state == SAC_CONV && sar_if.busy
		|=> !r.core_en && r.on ##1 r.state == SAC_IDLE)
		else $error("sleep on other clock did not abort and turn off");
	a_sleep_wake: assert property (s_done_in_sleep and r.ie |=> r.wake)
		else $error("completion in sleep did not wake");
	a_sleep_off: assert property (s_done_in_sleep and !r.ie |=> r.halted && r.on)
		else $error("completion in sleep did not turn converter off");
	a_trigger: assert property (trigger_i && can_start && r.state == SAC_IDLE
		|=> r.go && r.timer_reset)
		else $error("trigger did not set go and clear timer");
endmodule
`default_nettype wire

// ===== src/sac_pkg.sv
// Constants and types shared by the converter control block
package sac_pkg;
	localparam int RES_W = 10;
	localparam int IDX_W = 4;
	localparam int BYTE_W = 8;
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;

	localparam logic [APB_AW-1:0] OFS_CTRL   = 8'h00;
	localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] OFS_RES_HI = 8'h08;
	localparam logic [APB_AW-1:0] OFS_RES_LO = 8'h0C;

	localparam int CTRL_ON    = 0;
	localparam int CTRL_GO    = 1;
	localparam int CTRL_REFX  = 2;
	localparam int CTRL_FMT   = 3;
	localparam int CTRL_RCSEL = 4;
	localparam int CTRL_IE    = 5;
	localparam int STAT_DONE  = 0;
	localparam int STAT_BUSY  = 1;
	localparam int STAT_HALT  = 2;
	localparam int STAT_WAKE  = 3;

	localparam logic [BYTE_W-1:0] RESULT_RESET = 8'h00;
	localparam logic [3:0]        CNT_RESET    = 4'h0;

	localparam int CLK_PERIOD_PS  = 5000;
	localparam int INSTR_CYCLE_NS = 20;
	localparam int BIT_TIME_NS    = 40;
	localparam int INSTR_CYCLES   = (INSTR_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BIT_CYCLES     = (BIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [2:0] {
		SAC_IDLE  = 3'b001,
		SAC_DELAY = 3'b010,
		SAC_CONV  = 3'b100
	} sac_state_e;
endpackage

// ===== src/sac_sar.sv
// Successive-approximation register with partial-result abort
`timescale 1ns/10ps
`default_nettype none
module sac_sar
	import sac_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	sac_sar_if.sar    sar
);
	typedef struct packed {
		logic             busy;
		logic             done;
		logic [IDX_W-1:0] idx;
		logic [RES_W-1:0] acc;
	} sac_sar_s;

	sac_sar_s         r;
	sac_sar_s         next_r;
	logic [RES_W-1:0] below;
	logic [RES_W-1:0] cur_bit;
	logic             last_bit;

	// Bits at or below the bit under trial are still unresolved
	genvar g;
	generate
		for (g = 0; g < RES_W; g++) begin : g_mask
			assign below[g] = (IDX_W'(g) <= r.idx);
		end
	endgenerate
	assign cur_bit = below & ~(below >> 1);

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		last_bit = 1'b0;
		if (sar.start) begin
			next_r.busy = 1'b1;
			next_r.idx = IDX_W'(RES_W - 1);
			next_r.acc = '0;
		end else if (r.busy && sar.abort) begin
			// Nothing resolved yet leaves zeros
			if (r.idx != IDX_W'(RES_W - 1)) begin
				last_bit = r.acc[r.idx + IDX_W'(1)];
			end
			next_r.acc = (r.acc & ~below) | (below & {RES_W{last_bit}});
			next_r.busy = 1'b0;
			next_r.done = 1'b1;
		end else if (r.busy && sar.tick) begin
			next_r.acc[r.idx] = sar.comp;
			if (r.idx == '0) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end else begin
				next_r.idx = r.idx - IDX_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign sar.busy   = r.busy;
	assign sar.done   = r.done;
	assign sar.result = r.acc;
	assign sar.trial  = r.busy ? (r.acc | cur_bit) : r.acc;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_abort_ends_now: assert property (r.busy && sar.abort && !sar.start |=> r.done && !r.busy)
		else $error("abort did not end the conversion at once");
	a_abort_fill: assert property (r.busy && sar.abort && !sar.start && r.idx == 4'h4
		|=> r.acc[4:0] == {5{$past(r.acc[5])}})
		else $error("unresolved bits do not copy the last converted bit");
	a_full_length: assert property (r.busy && sar.tick && !sar.abort && !sar.start
		&& r.idx != 4'h0 |=> r.busy && r.idx == $past(r.idx) - 4'h1)
		else $error("conversion finished before ten bits");
endmodule
`default_nettype wire

// ===== src/sac_sar_if.sv
// Link between the control sequencer and the approximation register
`timescale 1ns/10ps
`default_nettype none
interface sac_sar_if
	import sac_pkg::*;
();
	logic             start;
	logic             abort;
	logic             tick;
	logic             comp;
	logic             busy;
	logic             done;
	logic [RES_W-1:0] trial;
	logic [RES_W-1:0] result;

	modport ctrl (output start, output abort, output tick, output comp,
		input busy, input done, input trial, input result);
	modport sar (input start, input abort, input tick, input comp,
		output busy, output done, output trial, output result);
endinterface
`default_nettype wire

// ===== src/sac_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module sac_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sac_sync_s;

	sac_sync_s r;
	sac_sync_s next_r;

	always_comb begin
		next_r.s1 = d_i;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q_o = r.s2;
endmodule
`default_nettype wire
